// *** inc/tap_pkg.sv ***
package tap_pkg;

   // Test port pins as seen at the pads
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } tap_in_type;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } tap_out_type;

   // Register widths
   localparam int IR_W  = 3;
   localparam int ID_W  = 32;
   localparam int BSR_W = 64;

   // Instruction codes
   localparam logic [IR_W-1:0] OP_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0] OP_IDCODE  = 3'h1;
   localparam logic [IR_W-1:0] OP_SAMPLEZ = 3'h2;
   localparam logic [IR_W-1:0] OP_RSVD_A  = 3'h3;
   localparam logic [IR_W-1:0] OP_SAMPLE  = 3'h4;
   localparam logic [IR_W-1:0] OP_RSVD_B  = 3'h5;
   localparam logic [IR_W-1:0] OP_RSVD_C  = 3'h6;
   localparam logic [IR_W-1:0] OP_BYPASS  = 3'h7;

   // Fixed pattern loaded in Capture-IR
   localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

   // Identification value; this value is arbitrary
   localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5679;

   // Cell that gates the output data bus under EXTEST
   localparam int OE_CELL = 47;

   // Reset values
   localparam logic [BSR_W-1:0] BSR_RESET = 64'h0;
   localparam logic [ID_W-1:0]  ID_RESET  = 32'h0;
   localparam logic             PIN_PULL  = 1'b1;

   // Test controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } tap_state_type;

endpackage

// *** hw/sram_boundary_scan_tap.sv ***
// Summary of operation
// - Inputs taken on test clock rise, serial output changed on its fall.
// - Mode select steers controller each rise; floating pin reads high.
// - Serial data enters register MSB; serial output comes from LSB.
// - Serial output driven only in shift states, undriven otherwise.
// - Five rises with mode select high always reach the reset state.
// - Port reset leaves memory operation untouched, accepted any time.
// - Power-up reset leaves serial output undriven and memory undisturbed.
// - Exactly one data register sits in the path, chosen by instruction.
// - Three-bit instruction register loaded serially in its shift state.
// - Identification instruction loaded at power up and in reset state.
// - Capture-IR loads binary 01 into two low instruction bits.
// - One-bit bypass register cleared in Capture-DR while bypass is selected.
// - Capture-DR snapshots pin ring; Shift-DR shifts boundary register.
// - Pin ring captured under extest, sample/preload and float-sample.
// - Chain holds spare cells for unconnected pins besides bump cells.
// - Identification instruction captures fixed 32-bit code and shifts it.
// - Shifted instruction takes effect only through Update-IR.
// - Float-sample selects boundary register and floats output bus.
// - Under extest cell 47 enables output bus; preset low at reset.
// - Extest drives preloaded cells onto pins, boundary register shifts.
`timescale 1ns/1ns
module sram_boundary_scan_tap #(
   parameter int BSR_LEN = tap_pkg::BSR_W
) (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire tap_pkg::tap_in_type  tap_in,
   output tap_pkg::tap_out_type      tap_out,
   input  wire logic [BSR_LEN-1:0]   ring_in,
   output logic      [BSR_LEN-1:0]   ring_out,
   output logic                      ring_drive,
   output logic                      q_bus_oe
);
   import tap_pkg::*;

   tap_state_type        state;
   tap_state_type        next_state;
   logic                 tck_s1;
   logic                 tck_s2;
   logic                 tck_prev;
   logic                 tms_s1;
   logic                 tms_s2;
   logic                 tdi_s1;
   logic                 tdi_s2;
   logic                 rise;
   logic                 fall;
   logic [IR_W-1:0]      ir_shift;
   logic [IR_W-1:0]      ir;
   logic                 bypass;
   logic [ID_W-1:0]      id_shift;
   logic [BSR_LEN-1:0]   bsr_shift;
   logic [BSR_LEN-1:0]   bsr_latch;
   logic                 sel_bsr;
   logic                 sel_id;
   logic                 dr_lsb;
   logic                 tdo;
   logic                 tdo_oe;

   // Pad synchronisers; mode select and data rest at pull-up level
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tck_s1 <= 1'b0;
         tck_s2 <= 1'b0;
         tck_prev <= 1'b0;
      end else begin
         tck_s1 <= tap_in.tck;
         tck_s2 <= tck_s1;
         tck_prev <= tck_s2;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tms_s1 <= PIN_PULL;
         tms_s2 <= PIN_PULL;
         tdi_s1 <= PIN_PULL;
         tdi_s2 <= PIN_PULL;
      end else begin
         tms_s1 <= tap_in.tms;
         tms_s2 <= tms_s1;
         tdi_s1 <= tap_in.tdi;
         tdi_s2 <= tdi_s1;
      end
   end

   // Test clock edges found from synchronised samples
   // A test clock phase shorter than one system clock can be missed
   assign rise = tck_s2 & ~tck_prev;
   assign fall = ~tck_s2 & tck_prev;

   // Controller next state from mode select
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET: begin
            if (tms_s2)
               next_state = ST_RESET;
            else
               next_state = ST_IDLE;
         end
         ST_IDLE: begin
            if (tms_s2)
               next_state = ST_SEL_DR;
            else
               next_state = ST_IDLE;
         end
         ST_SEL_DR: begin
            if (tms_s2)
               next_state = ST_SEL_IR;
            else
               next_state = ST_CAP_DR;
         end
         ST_CAP_DR: begin
            if (tms_s2)
               next_state = ST_EX1_DR;
            else
               next_state = ST_SH_DR;
         end
         ST_SH_DR: begin
            if (tms_s2)
               next_state = ST_EX1_DR;
            else
               next_state = ST_SH_DR;
         end
         ST_EX1_DR: begin
            if (tms_s2)
               next_state = ST_UPD_DR;
            else
               next_state = ST_PAU_DR;
         end
         ST_PAU_DR: begin
            if (tms_s2)
               next_state = ST_EX2_DR;
            else
               next_state = ST_PAU_DR;
         end
         ST_EX2_DR: begin
            if (tms_s2)
               next_state = ST_UPD_DR;
            else
               next_state = ST_SH_DR;
         end
         ST_UPD_DR: begin
            if (tms_s2)
               next_state = ST_SEL_DR;
            else
               next_state = ST_IDLE;
         end
         ST_SEL_IR: begin
            if (tms_s2)
               next_state = ST_RESET;
            else
               next_state = ST_CAP_IR;
         end
         ST_CAP_IR: begin
            if (tms_s2)
               next_state = ST_EX1_IR;
            else
               next_state = ST_SH_IR;
         end
         ST_SH_IR: begin
            if (tms_s2)
               next_state = ST_EX1_IR;
            else
               next_state = ST_SH_IR;
         end
         ST_EX1_IR: begin
            if (tms_s2)
               next_state = ST_UPD_IR;
            else
               next_state = ST_PAU_IR;
         end
         ST_PAU_IR: begin
            if (tms_s2)
               next_state = ST_EX2_IR;
            else
               next_state = ST_PAU_IR;
         end
         ST_EX2_IR: begin
            if (tms_s2)
               next_state = ST_UPD_IR;
            else
               next_state = ST_SH_IR;
         end
         ST_UPD_IR: begin
            if (tms_s2)
               next_state = ST_SEL_DR;
            else
               next_state = ST_IDLE;
         end
      endcase
   end

   // Controller state, advanced once per test clock rise
   always_ff @(posedge mclk) begin
      if (!rstn)
         state <= ST_RESET;
      else if (rise)
         state <= next_state;
   end

   // Instruction shift stage
   always_ff @(posedge mclk) begin
      if (!rstn)
         ir_shift <= OP_IDCODE;
      else if (rise) begin
         if (state == ST_CAP_IR)
            ir_shift <= IR_CAPTURE;
         else if (state == ST_SH_IR)
            ir_shift <= {tdi_s2, ir_shift[IR_W-1:1]};
      end
   end

   // Current instruction changes only at Update-IR or on entry to reset;
   // reloading on entry keeps the identification code in place even if
   // the test clock stops while the controller sits in reset
   always_ff @(posedge mclk) begin
      if (!rstn)
         ir <= OP_IDCODE;
      else if (rise) begin
         if (next_state == ST_RESET)
            ir <= OP_IDCODE;
         else if (state == ST_UPD_IR)
            ir <= ir_shift;
      end
   end

   // Data register selection; reserved codes fall back to bypass
   always_comb begin
      sel_bsr = 1'b0;
      sel_id = 1'b0;
      unique case (ir)
         OP_EXTEST,
         OP_SAMPLEZ,
         OP_SAMPLE: sel_bsr = 1'b1;
         OP_IDCODE: sel_id = 1'b1;
         OP_BYPASS,
         OP_RSVD_A,
         OP_RSVD_B,
         OP_RSVD_C: sel_id = 1'b0;
      endcase
   end

   // Bypass cell
   // Captures zero so a board test sees a known first bit
   always_ff @(posedge mclk) begin
      if (!rstn)
         bypass <= 1'b0;
      else if (rise && !sel_bsr && !sel_id) begin
         if (state == ST_CAP_DR)
            bypass <= 1'b0;
         else if (state == ST_SH_DR)
            bypass <= tdi_s2;
      end
   end

   // Identification register
   always_ff @(posedge mclk) begin
      if (!rstn)
         id_shift <= ID_RESET;
      else if (rise && sel_id) begin
         if (state == ST_CAP_DR)
            id_shift <= ID_VALUE;
         else if (state == ST_SH_DR)
            id_shift <= {tdi_s2, id_shift[ID_W-1:1]};
      end
   end

   // Boundary shift stage, spare cells included in the length
   always_ff @(posedge mclk) begin
      if (!rstn)
         bsr_shift <= BSR_LEN'(BSR_RESET);
      else if (rise && sel_bsr) begin
         if (state == ST_CAP_DR)
            bsr_shift <= ring_in;
         else if (state == ST_SH_DR)
            bsr_shift <= {tdi_s2, bsr_shift[BSR_LEN-1:1]};
      end
   end

   // Preload latch; entering reset presets the bus-enable cell low, so a
   // controller that parks in reset never leaves a stale test pattern
   always_ff @(posedge mclk) begin
      if (!rstn)
         bsr_latch <= BSR_LEN'(BSR_RESET);
      else if (rise) begin
         if (next_state == ST_RESET)
            bsr_latch <= BSR_LEN'(BSR_RESET);
         else if (state == ST_UPD_DR && sel_bsr)
            bsr_latch <= bsr_shift;
      end
   end

   // Pin control; normal operation whenever not in a test mode
   // Outputs follow the instruction, so they move only after a test clock rise
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ring_out <= BSR_LEN'(BSR_RESET);
         ring_drive <= 1'b0;
         q_bus_oe <= 1'b1;
      end else begin
         ring_out <= bsr_latch;
         ring_drive <= (ir == OP_EXTEST);
         if (ir == OP_EXTEST)
            q_bus_oe <= bsr_latch[OE_CELL];
         else if (ir == OP_SAMPLEZ)
            q_bus_oe <= 1'b0;
         else
            q_bus_oe <= 1'b1;
      end
   end

   // LSB of the one selected register
   always_comb begin
      if (state == ST_SH_IR)
         dr_lsb = ir_shift[0];
      else if (sel_bsr)
         dr_lsb = bsr_shift[0];
      else if (sel_id)
         dr_lsb = id_shift[0];
      else
         dr_lsb = bypass;
   end

   // Serial output updated on test clock fall
   // Enable follows the state so the pin floats outside the shift states
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (fall) begin
         tdo <= dr_lsb;
         tdo_oe <= (state == ST_SH_DR) || (state == ST_SH_IR);
      end
   end

   assign tap_out.tdo = tdo;
   assign tap_out.tdo_oe = tdo_oe;

endmodule

// *** verif/sram_boundary_scan_tap_chk.sv ***
`timescale 1ns/1ns
module sram_boundary_scan_tap_chk #(
   parameter int BSR_LEN = 64
) (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire tap_pkg::tap_in_type  tap_in,
   input  wire tap_pkg::tap_out_type tap_out,
   input  wire logic [BSR_LEN-1:0]   ring_in,
   input  wire logic [BSR_LEN-1:0]   ring_out,
   input  wire logic                 ring_drive,
   input  wire logic                 q_bus_oe
);
   import tap_pkg::*;
   logic       tck_q;
   logic [2:0] hi_cnt;
   logic       fifth;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Counts pad test clock rises with mode select high
   assign fifth = tap_in.tck && !tck_q && tap_in.tms && (hi_cnt == 3'h4);
   always_ff @(posedge mclk) begin
      tck_q <= rstn ? tap_in.tck : 1'b0;
      if (!rstn || (tap_in.tck && !tck_q && !tap_in.tms)) hi_cnt <= 3'h0;
      else if (tap_in.tck && !tck_q && hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
   end
   property p_reset;
      $rose(rstn) |-> !tap_out.tdo_oe && !ring_drive && q_bus_oe && ring_out == '0;
   endproperty
   a_reset: assert property (p_reset) else $error("bad output after reset");
   property p_tdo_fall;
      $changed(tap_out.tdo) |-> !$past(tap_in.tck, 2);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a falling edge");
   property p_oe_fall;
      $changed(tap_out.tdo_oe) |-> !$past(tap_in.tck, 2) && !$past(tap_in.tck, 1);
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved off a falling edge");
   property p_cell;
      ring_drive |-> q_bus_oe == ring_out[OE_CELL];
   endproperty
   a_cell: assert property (p_cell) else $error("bus enable differs from its cell");
   property p_ir_rise;
      $changed(ring_drive) |-> $past(tap_in.tck, 2);
   endproperty
   a_ir_rise: assert property (p_ir_rise) else $error("instruction changed off a rise");
   property p_latch_rise;
      $changed(ring_out) |-> $past(tap_in.tck, 2) && $past(tap_in.tck, 1);
   endproperty
   a_latch_rise: assert property (p_latch_rise) else $error("latch changed off a rise");
   property p_float;
      $changed(q_bus_oe) |-> $past(tap_in.tck, 2);
   endproperty
   a_float: assert property (p_float) else $error("bus enable changed off a rise");
   property p_five;
      fifth |-> ##[1:8] (ring_out == '0 && !ring_drive && q_bus_oe);
   endproperty
   a_five: assert property (p_five) else $error("five high rises did not reset");
   c_extest: cover property (ring_drive && !q_bus_oe);
   c_float: cover property (!ring_drive && !q_bus_oe);
   c_five: cover property (fifth);
endmodule
bind sram_boundary_scan_tap sram_boundary_scan_tap_chk #(.BSR_LEN(BSR_LEN)) chk (.mclk(mclk), .rstn(rstn),
   .tap_in(tap_in), .tap_out(tap_out), .ring_in(ring_in), .ring_out(ring_out), .ring_drive(ring_drive),
   .q_bus_oe(q_bus_oe));

// *** verif/tap_ctl_model.sv ***
`timescale 1ns/1ns
module tap_ctl_model (
   input  wire logic                 mclk,
   input  wire tap_pkg::tap_out_type tap_out,
   output tap_pkg::tap_in_type       tap_in
);
   import tap_pkg::*;
   // Idle pins rest at the pull-up level, clock held low
   initial tap_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
   // One 80 ns test clock cycle; tdo taken mid high phase, a released pin reads inverted
   task automatic tick(input logic ms, input logic di, output logic dout);
      tap_in.tms = ms;
      tap_in.tdi = di;
      repeat (4) @(negedge mclk);
      tap_in.tck = 1'b1;
      repeat (2) @(negedge mclk);
      dout = tap_out.tdo_oe ? tap_out.tdo : ~tap_out.tdo;
      repeat (2) @(negedge mclk);
      tap_in.tck = 1'b0;
   endtask
   // Mode select sequence, first bit first, then clock stands still
   task automatic go(input logic [7:0] seq, input int n);
      logic d;
      for (int i = 0; i < n; i++) tick(seq[i], 1'b1, d);
      tap_in.tdi = 1'b1;
      repeat (6) @(negedge mclk);
   endtask
   task automatic shift(input logic [BSR_W-1:0] din, input int n, output logic [BSR_W-1:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
   endtask
   // Ends in Exit1-IR; codes come only from the five defined ones
   task automatic ir_shift(input logic [IR_W-1:0] code, output logic [IR_W-1:0] cap);
      logic [BSR_W-1:0] o;
      go(8'h03, 4);
      shift({61'h0, code}, 3, o);
      cap = o[2:0];
   endtask
   task automatic ir_finish();
      go(8'h01, 2);
   endtask
   task automatic dr(input logic [BSR_W-1:0] din, input int n, output logic [BSR_W-1:0] dout);
      go(8'h01, 3);
      shift(din, n, dout);
      go(8'h01, 2);
   endtask
   task automatic reset5();
      go(8'h1F, 5);
      go(8'h00, 1);
   endtask
endmodule

// *** verif/sram_boundary_scan_tap_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, got); \
      end \
   end
module sram_boundary_scan_tap_tb_top;
   import tap_pkg::*;
   localparam logic [BSR_W-1:0] PRE_HI = 64'hA5A5_8000_5A5A_C33C;
   localparam logic [BSR_W-1:0] PRE_LO = 64'h0F0F_7FFF_F0F0_1234;
   logic             mclk = 1'b0;
   logic             rstn = 1'b0;
   logic [BSR_W-1:0] ring_in = 64'h0123_4567_89AB_CDEF;
   tap_in_type       tap_in;
   tap_out_type      tap_out;
   logic [BSR_W-1:0] ring_out;
   logic             ring_drive;
   logic             q_bus_oe;
   logic [BSR_W-1:0] so;
   logic [IR_W-1:0]  cap;
   int               miscompares = 0;
   int               check_count = 0;
   always #5 mclk = ~mclk;
   sram_boundary_scan_tap uut (.mclk(mclk), .rstn(rstn), .tap_in(tap_in), .tap_out(tap_out),
      .ring_in(ring_in), .ring_out(ring_out), .ring_drive(ring_drive), .q_bus_oe(q_bus_oe));
   tap_ctl_model ctl (.mclk(mclk), .tap_out(tap_out), .tap_in(tap_in));
   task automatic close_out();
      if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic ir_load(input logic [IR_W-1:0] code);
      ctl.ir_shift(code, cap);
      `CHK("ir capture", IR_CAPTURE, cap)
      ctl.ir_finish();
   endtask
   // Power-up state, then identification read
   task automatic t_power_up();
      `CHK("tdo enable", 1'b0, tap_out.tdo_oe)
      `CHK("bus enable", 1'b1, q_bus_oe)
      `CHK("latch", 64'h0, ring_out)
      ctl.go(8'h00, 1);
      `CHK("tdo enable idle", 1'b0, tap_out.tdo_oe)
      ctl.dr(64'h0, 32, so);
      `CHK("id", ID_VALUE, so[31:0])
   endtask
   // One-bit path, captured zero first
   task automatic t_bypass();
      ir_load(OP_BYPASS);
      ctl.dr(64'hD, 5, so);
      `CHK("bypass", 5'h1A, so[4:0])
   endtask
   // Sample, preload, extest drive and float-sample
   task automatic t_ring();
      ir_load(OP_SAMPLE);
      ctl.dr(PRE_HI, BSR_W, so);
      `CHK("sample", 64'h0123_4567_89AB_CDEF, so)
      `CHK("preload", PRE_HI, ring_out)
      `CHK("drive sample", 1'b0, ring_drive)
      ctl.ir_shift(OP_EXTEST, cap);
      `CHK("drive before update", 1'b0, ring_drive)
      ctl.ir_finish();
      `CHK("drive extest", 1'b1, ring_drive)
      `CHK("bus on", 1'b1, q_bus_oe)
      ring_in = 64'hFEDC_BA98_7654_3210;
      ctl.dr(PRE_LO, BSR_W, so);
      `CHK("extest capture", 64'hFEDC_BA98_7654_3210, so)
      `CHK("bus off", 1'b0, q_bus_oe)
      ir_load(OP_SAMPLEZ);
      ring_in = 64'h1111_2222_4444_8888;
      ctl.dr(PRE_HI, BSR_W, so);
      `CHK("float capture", 64'h1111_2222_4444_8888, so)
      `CHK("float bus", 1'b0, q_bus_oe)
      `CHK("float drive", 1'b0, ring_drive)
   endtask
   // Five high rises from inside Shift-DR under extest
   task automatic t_tap_reset();
      ir_load(OP_EXTEST);
      ctl.go(8'h01, 3);
      ctl.reset5();
      `CHK("reset drive", 1'b0, ring_drive)
      `CHK("reset latch", 64'h0, ring_out)
      `CHK("reset bus", 1'b1, q_bus_oe)
      ctl.dr(64'h0, 32, so);
      `CHK("reset id", ID_VALUE, so[31:0])
   endtask
   initial begin
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      t_power_up();
      t_bypass();
      t_ring();
      t_tap_reset();
      close_out();
   end
   // Watchdog well beyond the roughly 3000 cycles of traffic
   initial begin
      #300000;
      miscompares++;
      close_out();
   end
endmodule
